//--- rtl/bcm_clock_mode_ctrl.sv
// Purpose: bus clock source and run-mode clocking control
// Assumes: clock sources and loop analog are outside; this block steers them
// Notes: the bus clock itself is gated outside from the leg enables
//
// Behaviour
// - after system or power-on reset the block is in internal-reference locked mode on the loop output.
// - at reset the loop targets 50 MHz, post divider 0x03 (divide by 4), bus at half that.
// - in internal-reference locked mode the loop reference is the internal RC reference.
// - in both locked modes the bus runs from the loop output, whose settings may be changed.
// - in bypass mode the bus runs from the crystal and the loop keeps running to qualify it.
// - in run mode the loop and internal reference run, regulator is full power, periodic timer available.
// - wait mode behaves exactly like run mode.
// - after reset the factory frequency trim is loaded into the trim register; software may overwrite it.
// - the loaded trim leaves temperature trimming off; software may enable it by rewriting.
// - system reset on power-on, low voltage, watchdog, crystal monitor, loop monitor or reset pin low.
// - the lock detector requests an interrupt on entry to and exit from lock.
// - bus source is loop output or crystal, with a programmable divider on the loop output.
`timescale 1ns/1ns
module bcm_clock_mode_ctrl
   import bcm_pkg::*;
#(
   parameter int POSTDIV_WIDTH = POSTDIV_W,
   parameter int STRETCH = RESET_STRETCH_CYC
)(
   input wire logic clk, // 25 MHz control clock
   input wire logic srst, // synchronous reset
   input wire logic powerOnEvt, // power-on detector
   input wire logic lowVoltageEvt, // low supply detector
   input wire logic watchdogEvt, // watchdog timeout or window fault
   input wire logic oscMonFail, // crystal monitor failure
   input wire logic loopMonFail, // loop clock monitor failure
   input wire logic resetPin_n, // external reset pin level
   input wire logic waitMode, // cpu in wait
   input wire logic busSourceSelectWr, // write strobe for source select
   input wire logic busSourceSelectIn, // 1 loop output, 0 crystal
   input wire logic crystalOscEnableWr, // write strobe for crystal enable
   input wire logic crystalOscEnableIn, // crystal enable value
   input wire logic refDivWr, // write strobe for reference divider
   input wire logic [REFDIV_W-1:0] refDivIn, // reference divider value
   input wire logic postDivWr, // write strobe for post divider
   input wire logic [POSTDIV_WIDTH-1:0] postDivIn, // post divider value
   input wire logic trimWr, // software write of trim register
   input wire logic [TRIM_W-1:0] trimIn, // software trim value
   input wire logic factoryTrimValid, // factory trim fetched from nvm
   input wire logic [TRIM_W-1:0] factoryTrim, // factory 1 MHz trim
   input wire logic crystalOscReadyIn, // crystal started up
   input wire logic loopLockIn, // raw lock detector level
   output logic systemReset, // system reset request
   output logic busSourceSelect, // source select register
   output logic crystalOscEnable, // crystal oscillator enable
   output logic crystalOscReady, // crystal ready status
   output logic loopLocked, // lock status
   output logic lockChangeIrq, // one-cycle pulse on lock change
   output logic [REFDIV_W-1:0] referenceDivider, // reference divider
   output logic [POSTDIV_WIDTH-1:0] postDivider, // post divider
   output logic loopRefInternal, // 1 loop reference is internal rc
   output logic loopEnable, // loop oscillator running
   output logic rcRefEnable, // internal rc reference running
   output logic regulatorFullPower, // regulator full performance
   output logic periodicTimerAvail, // periodic timer available
   output logic [TRIM_W-1:0] rcTrim, // rc trim register
   output logic trimLoaded, // factory trim loaded or trim written by software
   output logic loopLegEn, // bus gate from loop output leg
   output logic oscLegEn, // bus gate from crystal leg
   output logic [1:0] modeCode // current mode (bcm_mode_t order)
);
   // refused at elaboration: the stretch counter is four bits wide and
   // the post divider reset value needs at least two bits
   if (POSTDIV_WIDTH < 2 || POSTDIV_WIDTH > 8) begin : g_bad_postdiv
      $error("post divider width unsupported");
   end
   if (STRETCH < 1 || STRETCH > 15) begin : g_bad_stretch
      $error("reset stretch unsupported");
   end

   logic busSourceSelect_reg, crystalOscEnable_reg, lockedPrev_reg, lockIrq_reg;
   logic crystalOscReady_reg, loopLocked_reg, trimLoaded_reg, sysRst_reg, loopRefInt_reg;
   logic [REFDIV_W-1:0] refDiv_reg;
   logic [POSTDIV_WIDTH-1:0] postDiv_reg;
   logic [TRIM_W-1:0] trim_reg;
   logic [3:0] stretch_reg;
   logic [1:0] modeCode_reg;
   logic resetEvent, lockChange, muxSwitching, selLoop;
   bcm_mode_t modeNext;

   // any one source asserts the system reset; held a few cycles
   assign resetEvent = powerOnEvt | lowVoltageEvt | watchdogEvt | oscMonFail
      | loopMonFail | ~resetPin_n;
   assign lockChange = loopLocked_reg ^ lockedPrev_reg;
   // crystal leg as soon as select clears; software owns the ready wait
   assign selLoop = busSourceSelect_reg;

   // mode decode: select=1 locked on loop; reference from crystal once enabled and ready
   always_comb begin
      if (!busSourceSelect_reg) modeNext = MODE_BYPASS;
      else if (crystalOscEnable_reg && crystalOscReady_reg) modeNext = MODE_EXT_LOCKED;
      else modeNext = MODE_INT_LOCKED;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sysRst_reg <= 1'b0;
         stretch_reg <= 4'h0;
      end else if (resetEvent) begin
         sysRst_reg <= 1'b1;
         stretch_reg <= 4'(STRETCH);
      end else if (stretch_reg != 4'h0) begin
         stretch_reg <= stretch_reg - 4'h1;
      end else begin
         sysRst_reg <= 1'b0;
      end
   end

   // the reset request resets configuration like srst does
   always_ff @(posedge clk) begin
      if (srst || sysRst_reg) begin
         busSourceSelect_reg <= 1'b1;
         crystalOscEnable_reg <= 1'b0;
         refDiv_reg <= REFDIV_RST;
         postDiv_reg <= POSTDIV_WIDTH'(POSTDIV_RST);
      end else begin
         if (busSourceSelectWr) busSourceSelect_reg <= busSourceSelectIn;
         if (crystalOscEnableWr) crystalOscEnable_reg <= crystalOscEnableIn;
         if (refDivWr) refDiv_reg <= refDivIn;
         if (postDivWr) postDiv_reg <= postDivIn;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || sysRst_reg) begin
         crystalOscReady_reg <= 1'b0;
         loopLocked_reg <= 1'b0;
         lockedPrev_reg <= 1'b0;
         lockIrq_reg <= 1'b0;
         modeCode_reg <= 2'h0;
         loopRefInt_reg <= 1'b1;
      end else begin
         // ready only counts while the crystal is enabled
         crystalOscReady_reg <= crystalOscReadyIn & crystalOscEnable_reg;
         loopLocked_reg <= loopLockIn;
         lockedPrev_reg <= loopLocked_reg;
         lockIrq_reg <= lockChange;
         modeCode_reg <= 2'(modeNext);
         // registered with the mode so the output comes from a flop
         loopRefInt_reg <= (modeNext == MODE_INT_LOCKED);
      end
   end

   // nvm fetch finishes after reset; a software write in that same cycle wins
   // since it is the newer intent
   always_ff @(posedge clk) begin
      if (srst || sysRst_reg) begin
         trim_reg <= {TRIM_W{1'b0}};
         trimLoaded_reg <= 1'b0;
      end else if (trimWr) begin
         trim_reg <= trimIn;
         trimLoaded_reg <= 1'b1;
      end else if (!trimLoaded_reg && factoryTrimValid) begin
         trim_reg <= {factoryTrim[TRIM_W-1:TRIM_TC_LSB+TRIM_TC_W], TC_OFF,
            factoryTrim[TRIM_TC_LSB-1:0]};
         trimLoaded_reg <= 1'b1;
      end
   end

   bcm_glitch_free_mux u_mux (
      .clk(clk),
      .srst(srst | sysRst_reg),
      .selLoop(selLoop),
      .loopLegEn(loopLegEn),
      .oscLegEn(oscLegEn),
      .switching(muxSwitching)
   );

   assign systemReset = sysRst_reg;
   assign busSourceSelect = busSourceSelect_reg;
   assign crystalOscEnable = crystalOscEnable_reg;
   assign crystalOscReady = crystalOscReady_reg;
   assign loopLocked = loopLocked_reg;
   assign lockChangeIrq = lockIrq_reg;
   assign referenceDivider = refDiv_reg;
   assign postDivider = postDiv_reg;
   assign rcTrim = trim_reg;
   assign trimLoaded = trimLoaded_reg;
   assign modeCode = modeCode_reg;
   // loop, rc and regulator stay up in run and wait alike
   assign loopEnable = 1'b1;
   assign rcRefEnable = 1'b1;
   assign regulatorFullPower = 1'b1;
   assign periodicTimerAvail = 1'b1;
   assign loopRefInternal = loopRefInt_reg;

   a_reset_mode: assert property (@(posedge clk)
      $fell(sysRst_reg) |-> busSourceSelect_reg && modeCode_reg == 2'h0)
      else $error("not internal locked mode after reset");
   a_post_div_reset: assert property (@(posedge clk)
      srst |=> postDiv_reg == POSTDIV_WIDTH'(POSTDIV_RST)) else $error("post divider reset wrong");
   a_reset_source: assert property (@(posedge clk) disable iff (srst)
      resetEvent |=> sysRst_reg [*2]) else $error("reset event not stretched");
   a_lock_irq: assert property (@(posedge clk) disable iff (srst || sysRst_reg)
      $changed(loopLocked_reg) |=> lockIrq_reg) else $error("lock change lost");
   a_bypass_mode: assert property (@(posedge clk) disable iff (srst || sysRst_reg)
      !busSourceSelect_reg |=> modeCode_reg == 2'(MODE_BYPASS)) else $error("bypass not entered");
   a_ext_mode: assert property (@(posedge clk) disable iff (srst || sysRst_reg)
      busSourceSelect_reg && crystalOscEnable_reg && crystalOscReady_reg |=>
      modeCode_reg == 2'(MODE_EXT_LOCKED))
      else $error("external locked not entered");
   a_trim_tc_off: assert property (@(posedge clk) disable iff (srst || sysRst_reg)
      !trimLoaded_reg && factoryTrimValid && !trimWr |=>
      trim_reg[TRIM_TC_LSB+:TRIM_TC_W] == TC_OFF) else $error("tc trim not off");
   a_trim_sw_write: assert property (@(posedge clk) disable iff (srst || sysRst_reg)
      trimWr |=> trim_reg == $past(trimIn)) else $error("trim write lost");
   a_leg_follows: assert property (@(posedge clk) disable iff (srst || sysRst_reg)
      busSourceSelect_reg [*3] |-> loopLegEn && !oscLegEn) else $error("loop leg not on");
   a_reset_config: assert property (@(posedge clk) disable iff (srst)
      sysRst_reg |=> busSourceSelect_reg && !crystalOscEnable_reg) else $error("config not reset");
   a_reset_loop_leg: assert property (@(posedge clk) disable iff (srst)
      $fell(sysRst_reg) |-> loopLegEn && !oscLegEn) else $error("loop leg off after reset");
   a_wait_like_run: assert property (@(posedge clk) disable iff (srst)
      waitMode |-> loopEnable && rcRefEnable && regulatorFullPower && periodicTimerAvail)
      else $error("wait mode differs from run");
   c_to_bypass: cover property (@(posedge clk) modeCode_reg == 2'(MODE_BYPASS) && oscLegEn);
   c_to_ext: cover property (@(posedge clk) modeCode_reg == 2'(MODE_EXT_LOCKED));
   c_lock_irq: cover property (@(posedge clk) lockIrq_reg);
   c_mux_switch: cover property (@(posedge clk) muxSwitching);
endmodule

//--- rtl/bcm_glitch_free_mux.sv
// Purpose: glitch-free selection between two clock sources
// Assumes: selects and enables timed in the clk domain
// Notes: break-before-make except at reset; otherwise neither leg enables until the other is off
`timescale 1ns/1ns
module bcm_glitch_free_mux
   import bcm_pkg::*;
(
   input wire logic clk, // control clock
   input wire logic srst, // synchronous reset
   input wire logic selLoop, // 1 picks loop output leg
   output logic loopLegEn, // loop leg gate enable
   output logic oscLegEn, // crystal leg gate enable
   output logic switching // high while a change is pending
);
   logic loopLegEn_reg, oscLegEn_reg;
   logic loopLegEn_next, oscLegEn_next;

   // except under reset, which sets the loop leg at once, an enable may rise only once the other leg has been off for a cycle,
   // so the downstream gate never sees two active legs
   assign loopLegEn_next = selLoop & ~oscLegEn_reg;
   assign oscLegEn_next = ~selLoop & ~loopLegEn_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         loopLegEn_reg <= 1'b1;
         oscLegEn_reg <= 1'b0;
      end else begin
         loopLegEn_reg <= loopLegEn_next;
         oscLegEn_reg <= oscLegEn_next;
      end
   end

   assign loopLegEn = loopLegEn_reg;
   assign oscLegEn = oscLegEn_reg;
   assign switching = (selLoop != loopLegEn_reg) | (~selLoop != oscLegEn_reg);

   a_legs_exclusive: assert property (@(posedge clk) disable iff (srst)
      !(loopLegEn_reg && oscLegEn_reg)) else $error("both clock legs enabled");
endmodule

//--- shared/bcm_pkg.sv
// Purpose: constants for the bus clock mode control block
// Assumes: single 25 MHz clock, synchronous active-high reset
// Notes: trim layout and divider widths shared by both design files
package bcm_pkg;
   localparam int CLK_MHZ = 25;
   localparam int POSTDIV_W = 5;
   localparam logic [4:0] POSTDIV_RST = 5'h03;
   localparam int REFDIV_W = 4;
   localparam logic [3:0] REFDIV_RST = 4'h0;
   localparam int TRIM_W = 16;
   localparam int TRIM_TC_LSB = 10;
   localparam int TRIM_TC_W = 4;
   localparam logic [3:0] TC_OFF = 4'h0;
   localparam int VCO_RST_MHZ = 50;
   localparam int RESET_STRETCH_CYC = 4;
   localparam int SW_SYNC_STAGES = 2;
   typedef enum {
      MODE_INT_LOCKED,
      MODE_EXT_LOCKED,
      MODE_BYPASS
   } bcm_mode_t;
endpackage

//--- verification/bus_clock_mode_control_tb.sv
// Purpose: self-checking bench for the bus clock mode control block
// Assumes: inputs move on the falling edge; 25 MHz clock, sync reset
// Notes: leg enables are watched every cycle, overlap would glitch the bus clock
`timescale 1ns/1ns
module bus_clock_mode_control_tb
   import bcm_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [5:0] srcVec = 6'h00; // bit 0 pulls the reset pin low
   wire powerOnEvt, lowVoltageEvt, watchdogEvt, oscMonFail, loopMonFail, resetPin_n;
   logic waitMode = 1'b0, busSourceSelectWr = 1'b0, busSourceSelectIn = 1'b0;
   logic crystalOscEnableWr = 1'b0, crystalOscEnableIn = 1'b0, refDivWr = 1'b0;
   logic [3:0] refDivIn = 4'h0;
   logic postDivWr = 1'b0, trimWr = 1'b0, factoryTrimValid = 1'b1;
   logic [4:0] postDivIn = 5'h00;
   logic [15:0] trimIn = 16'h0000, factoryTrim = 16'hffff;
   logic crystalOscReadyIn = 1'b0, loopLockIn = 1'b0;
   logic systemReset, busSourceSelect, crystalOscEnable, crystalOscReady, loopLocked;
   logic lockChangeIrq, loopRefInternal, loopEnable, rcRefEnable, regulatorFullPower;
   logic periodicTimerAvail, trimLoaded, loopLegEn, oscLegEn;
   logic [3:0] referenceDivider;
   logic [4:0] postDivider;
   logic [15:0] rcTrim;
   logic [1:0] modeCode;
   int n_mismatch = 0, checks_done = 0, cyc = 0;

   assign {powerOnEvt, lowVoltageEvt, watchdogEvt, oscMonFail, loopMonFail, resetPin_n} =
      srcVec ^ 6'h01;

   bcm_clock_mode_ctrl DUT (.clk(clk), .srst(srst), .powerOnEvt(powerOnEvt),
      .lowVoltageEvt(lowVoltageEvt), .watchdogEvt(watchdogEvt), .oscMonFail(oscMonFail),
      .loopMonFail(loopMonFail), .resetPin_n(resetPin_n), .waitMode(waitMode),
      .busSourceSelectWr(busSourceSelectWr), .busSourceSelectIn(busSourceSelectIn),
      .crystalOscEnableWr(crystalOscEnableWr), .crystalOscEnableIn(crystalOscEnableIn),
      .refDivWr(refDivWr), .refDivIn(refDivIn), .postDivWr(postDivWr),
      .postDivIn(postDivIn), .trimWr(trimWr), .trimIn(trimIn),
      .factoryTrimValid(factoryTrimValid), .factoryTrim(factoryTrim),
      .crystalOscReadyIn(crystalOscReadyIn), .loopLockIn(loopLockIn),
      .systemReset(systemReset), .busSourceSelect(busSourceSelect),
      .crystalOscEnable(crystalOscEnable), .crystalOscReady(crystalOscReady),
      .loopLocked(loopLocked), .lockChangeIrq(lockChangeIrq),
      .referenceDivider(referenceDivider), .postDivider(postDivider),
      .loopRefInternal(loopRefInternal), .loopEnable(loopEnable), .rcRefEnable(rcRefEnable),
      .regulatorFullPower(regulatorFullPower), .periodicTimerAvail(periodicTimerAvail),
      .rcTrim(rcTrim), .trimLoaded(trimLoaded), .loopLegEn(loopLegEn),
      .oscLegEn(oscLegEn), .modeCode(modeCode));

   always #20 clk = ~clk;

   task final_report();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(bit ok, string m);
      checks_done++;
      if (!ok) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask

   // strobe for one cycle, then one idle cycle so strobes never merge
   task wr(int r, logic [15:0] v);
      case (r)
         0: begin
            busSourceSelectIn = v[0];
            busSourceSelectWr = 1'b1;
         end
         1: begin
            crystalOscEnableIn = v[0];
            crystalOscEnableWr = 1'b1;
         end
         2: begin
            refDivIn = v[3:0];
            refDivWr = 1'b1;
         end
         3: begin
            postDivIn = v[4:0];
            postDivWr = 1'b1;
         end
         default: begin
            trimIn = v;
            trimWr = 1'b1;
         end
      endcase
      @(negedge clk);
      {busSourceSelectWr, crystalOscEnableWr, refDivWr, postDivWr, trimWr} = 5'h00;
      @(negedge clk);
   endtask

   task cnt_irq(output int c);
      c = 0;
      repeat (6) begin
         @(negedge clk);
         if (lockChangeIrq === 1'b1) c++;
      end
   endtask

   task t_reset();
      chk(busSourceSelect === 1'b1 && modeCode === 2'h0, "not internal locked");
      chk(postDivider === 5'h03 && referenceDivider === 4'h0, "divider reset");
      chk(loopRefInternal === 1'b1, "reference not internal");
      chk(loopEnable === 1'b1 && rcRefEnable === 1'b1 && regulatorFullPower === 1'b1 &&
         periodicTimerAvail === 1'b1, "run mode supplies");
      chk(loopLegEn === 1'b1 && oscLegEn === 1'b0 && crystalOscEnable === 1'b0, "legs");
      chk(rcTrim === 16'hc3ff && trimLoaded === 1'b1, "factory trim");
      wr(4, 16'h3c00);
      chk(rcTrim === 16'h3c00, "trim overwrite");
      $display("test reset defaults done");
   endtask

   task t_ext();
      int c;
      wr(3, 16'h0001);
      chk(postDivider === 5'h01, "post divider write");
      wr(2, 16'h0005);
      wr(1, 16'h0001);
      chk(referenceDivider === 4'h5 && crystalOscEnable === 1'b1, "setup");
      crystalOscReadyIn = 1'b1;
      loopLockIn = 1'b1;
      cnt_irq(c);
      chk(c == 1, "lock entry request");
      chk(crystalOscReady === 1'b1 && loopLocked === 1'b1 && modeCode === 2'h1 &&
         loopLegEn === 1'b1 && loopRefInternal === 1'b0, "external locked");
      loopLockIn = 1'b0;
      cnt_irq(c);
      chk(c == 1 && loopLocked === 1'b0, "lock exit request");
      loopLockIn = 1'b1;
      cnt_irq(c);
      chk(c == 1 && loopLocked === 1'b1, "lock re-entry request");
      $display("test external locked done");
   endtask

   task t_bypass();
      waitMode = 1'b1; // wait must look exactly like run
      wr(0, 16'h0000);
      repeat (3) @(negedge clk);
      chk(modeCode === 2'h2 && oscLegEn === 1'b1 && loopLegEn === 1'b0, "bypass");
      chk(loopEnable === 1'b1, "loop stopped in bypass");
      wr(0, 16'h0001);
      repeat (3) @(negedge clk);
      chk(modeCode === 2'h1 && loopLegEn === 1'b1 && oscLegEn === 1'b0, "back");
      waitMode = 1'b0;
      $display("test bypass done");
   endtask

   task t_sources();
      int n;
      for (int i = 0; i < 6; i++) begin
         // each reset drops the crystal enable, so bypass is re-entered properly
         wr(1, 16'h0001);
         chk(crystalOscReady === 1'b1, "crystal not ready before bypass");
         wr(0, 16'h0000);
         srcVec = 6'h01 << i;
         @(negedge clk);
         chk(systemReset === 1'b1, "no system reset");
         srcVec = 6'h00;
         wr(3, 16'h001f); // refused while reset stands
         n = 0;
         while (systemReset !== 1'b0 && n < 12) begin
            @(negedge clk);
            n++;
         end
         repeat (3) @(negedge clk);
         chk(n < 12 && busSourceSelect === 1'b1 && postDivider === 5'h03 &&
            modeCode === 2'h0, "reset did not restore");
         chk(rcTrim === 16'hc3ff && trimLoaded === 1'b1, "trim not reloaded");
      end
      $display("test reset sources done");
   endtask

   always @(posedge clk) begin
      cyc++;
      if (!srst && loopLegEn === 1'b1 && oscLegEn === 1'b1) chk(1'b0, "both legs on");
      if (cyc == 4000) begin
         n_mismatch++;
         $display("unexpected at %0t: run too long", $time);
         final_report();
      end
   end

   initial begin
      int n;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      n = 0;
      while (trimLoaded !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      t_reset();
      t_ext();
      t_bypass();
      t_sources();
      final_report();
   end
endmodule
